/* File: bench/dbm_core_monitor.sv */
// Purpose: port checker for the lane masking core
// Assumes: input clock levels sampled on sys_clk_i, parked high in reset
// Notes: rises of the input clocks are rebuilt here from the sampled levels
`timescale 1ns/100ps
`default_nettype none
module dbm_core_monitor #(
   parameter int unsigned DATA_W = 36
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic clk_true_i,
   input wire logic clk_comp_i,
   input wire logic load_strobe_n_i,
   input wire logic read_write_select_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic rdata_oe_n_o,
   input wire logic busy_o,
   input wire logic ready_o
);
   logic tq, cq, rd_seen, tr, cr, go;
   logic [7:0] bcnt;
   assign tr = clk_true_i & !tq;
   assign cr = clk_comp_i & !cq;
   assign go = tr & !load_strobe_n_i & !busy_o;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tq <= 1'b1;
         cq <= 1'b1;
         rd_seen <= 1'b0;
         bcnt <= 8'h00;
      end else begin
         tq <= clk_true_i;
         cq <= clk_comp_i;
         rd_seen <= rd_seen | (go & read_write_select_i);
         bcnt <= busy_o ? bcnt + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   property p_rst; $rose(rst_b_i) |-> rdata_oe_n_o && !busy_o; endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_quiet; !rd_seen |-> rdata_oe_n_o; endproperty
   a_quiet: assert property (p_quiet) else $error("data driven before any read");
   property p_wr; go && !read_write_select_i |-> ##[1:2] busy_o; endproperty
   a_wr: assert property (p_wr) else $error("write load not taken");
   property p_rd; go && read_write_select_i |-> ##[1:20] !rdata_oe_n_o; endproperty
   a_rd: assert property (p_rd) else $error("read data never driven");
   property p_launch; $changed(rdata_o) |-> $past(tr || cr) || $past(tr || cr, 2); endproperty
   a_launch: assert property (p_launch) else $error("read data moved off a clock rise");
   property p_rdy; !ready_o |-> busy_o; endproperty
   a_rdy: assert property (p_rdy) else $error("queue full while idle");
   property p_bnd; bcnt < 8'd200; endproperty
   a_bnd: assert property (p_bnd) else $error("write beats never retired");
   property p_nop; tr && load_strobe_n_i && !busy_o |=> !busy_o; endproperty
   a_nop: assert property (p_nop) else $error("idle cycle started work");
endmodule : dbm_core_monitor
bind dbm_core dbm_core_monitor #(.DATA_W(DATA_W)) u_mon (.sys_clk_i, .rst_b_i, .clk_true_i,
   .clk_comp_i, .load_strobe_n_i, .read_write_select_i, .rdata_o, .rdata_oe_n_o, .busy_o,
   .ready_o);
`default_nettype wire

/* File: bench/dbm_ctl_model.sv */
// Purpose: memory controller model driving clocks, control and write beats
// Assumes: each input clock half lasts three system cycles
// Notes: clocks stand still between calls of h
`timescale 1ns/100ps
`default_nettype none
module dbm_ctl_model (
   input wire logic sys_clk_i,
   output logic clk_true_o,
   output logic clk_comp_o,
   output logic load_strobe_n_o,
   output logic read_write_select_o,
   output logic [dbm_pkg::ADDR_W-1:0] addr_o,
   output logic [dbm_pkg::DATA_W-1:0] wdata_o,
   output logic [dbm_pkg::SEL_W-1:0] byte_write_select_n_o
);
   initial begin
      clk_true_o = 1'b1;
      clk_comp_o = 1'b1;
      load_strobe_n_o = 1'b1;
      read_write_select_o = 1'b1;
      addr_o = '0;
      wdata_o = '0;
      byte_write_select_n_o = 4'hf;
   end
   // one half period: tr high gives a true rise, low a complementary rise
   task automatic h(input logic tr, ld, rw, input logic [19:0] a, input logic [35:0] d,
                    input logic [3:0] s);
      @(negedge sys_clk_i);
      clk_true_o = tr;
      clk_comp_o = !tr;
      load_strobe_n_o = ld;
      read_write_select_o = rw;
      addr_o = a;
      wdata_o = d;
      byte_write_select_n_o = s;
      repeat (2) @(negedge sys_clk_i);
   endtask : h
   task automatic park;
      @(negedge sys_clk_i);
      clk_true_o = 1'b1;
      clk_comp_o = 1'b1;
   endtask : park
endmodule : dbm_ctl_model
`default_nettype wire

/* File: bench/tb_ddr_sram_byte_write_mask.sv */
// Purpose: self-checking bench for the lane masking core
// Assumes: array contents are only known once written
// Notes: each organisation writes a full pair, then a masked pair, then reads back
`timescale 1ns/100ps
`default_nettype none
module tb_ddr_sram_byte_write_mask;
   localparam logic [15:0] SEL0 = 16'hadee;
   localparam logic [15:0] SEL1 = 16'h5efd;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   dbm_pkg::dbm_org_t org_i;
   logic clk_true_i, clk_comp_i, load_strobe_n_i, read_write_select_i;
   logic [19:0] addr_i;
   logic [35:0] wdata_i, rdata_o;
   logic [3:0] byte_write_select_n_i;
   logic rdata_oe_n_o, busy_o, ready_o;
   int n_errors = 0;
   int compares = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   dbm_core dut (.sys_clk_i, .rst_b_i, .org_i, .clk_true_i, .clk_comp_i, .load_strobe_n_i,
      .read_write_select_i, .addr_i, .wdata_i, .byte_write_select_n_i, .rdata_o,
      .rdata_oe_n_o, .busy_o, .ready_o);
   dbm_ctl_model m (.sys_clk_i, .clk_true_o(clk_true_i), .clk_comp_o(clk_comp_i),
      .load_strobe_n_o(load_strobe_n_i), .read_write_select_o(read_write_select_i),
      .addr_o(addr_i), .wdata_o(wdata_i), .byte_write_select_n_o(byte_write_select_n_i));
   task automatic summarize;
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [35:0] g, e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   function automatic logic [35:0] lm(input dbm_pkg::dbm_org_t o, input logic [3:0] s);
      case (o)
         dbm_pkg::DBM_ORG_X8: lm = {28'h0, {4{~s[1]}}, {4{~s[0]}}};
         dbm_pkg::DBM_ORG_X9: lm = {27'h0, {9{~s[0]}}};
         dbm_pkg::DBM_ORG_X18: lm = {18'h0, {9{~s[1]}}, {9{~s[0]}}};
         default: lm = {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
      endcase
   endfunction : lm
   // address half carries low selects and junk data, which must be ignored
   task automatic wr(input logic [19:0] a, input logic [35:0] d0, input logic [3:0] s0,
                     input logic [35:0] d1, input logic [3:0] s1);
      m.h(1'b1, 1'b0, 1'b0, a, ~d0, 4'h0);
      m.h(1'b0, 1'b1, 1'b0, a, ~d1, 4'h0);
      m.h(1'b1, 1'b1, 1'b0, a, d0, s0);
      m.h(1'b0, 1'b1, 1'b0, a, d1, s1);
   endtask : wr
   task automatic rd(input logic [19:0] a, output logic [35:0] q0, q1);
      for (int i = 0; i < 8; i++) begin
         m.h(!i[0], i != 0, 1'b1, a, 36'h0, 4'h0);
         if (i == 5) q0 = rdata_o;
         if (i == 6) q1 = rdata_o;
         if (i == 4) chk({35'h0, rdata_oe_n_o}, 36'h1);
         if (i == 5) chk({35'h0, rdata_oe_n_o}, 36'h0);
      end
      chk({35'h0, rdata_oe_n_o}, 36'h1);
   endtask : rd
   task automatic wait_idle;
      for (int i = 0; i < 300 && busy_o !== 1'b0; i++) @(negedge sys_clk_i);
      if (busy_o !== 1'b0) begin
         n_errors++;
         summarize();
      end
   endtask : wait_idle
   task automatic t_reset;
      @(negedge sys_clk_i);
      chk({33'h0, ready_o, rdata_oe_n_o, busy_o}, 36'h6);
   endtask : t_reset
   task automatic t_masks;
      logic [35:0] p, q, d0, d1, m0, m1, wm, q0, q1;
      logic [3:0] s0, s1;
      logic [19:0] a;
      m.h(1'b0, 1'b1, 1'b0, 20'h0, 36'h0, 4'hf);
      for (int k = 0; k < 4; k++) begin
         org_i = dbm_pkg::dbm_org_t'(k);
         s0 = SEL0[4*k +: 4];
         s1 = SEL1[4*k +: 4];
         a = 20'(4 * k + 2);
         p = 36'h3c5a96c3e ^ {9{4'(k)}};
         q = ~p;
         d0 = 36'h9e3779b97;
         d1 = ~d0 ^ {9{4'(k)}};
         wr(a, p, 4'h0, q, 4'h0);
         wr(a, d0, s0, d1, s1);
         m.h(1'b1, 1'b1, 1'b0, a, 36'h0, 4'h0);
         m.h(1'b0, 1'b1, 1'b0, a, 36'h0, 4'h0);
         wait_idle();
         chk({35'h0, ready_o}, 36'h1);
         rd(a, q0, q1);
         wm = lm(org_i, 4'h0);
         m0 = lm(org_i, s0);
         m1 = lm(org_i, s1);
         chk(q0 & wm, ((d0 & m0) | (p & ~m0)) & wm);
         chk(q1 & wm, ((d1 & m1) | (q & ~m1)) & wm);
      end
   endtask : t_masks
   initial begin
      org_i = dbm_pkg::DBM_ORG_X36;
      repeat (16) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      t_reset();
      t_masks();
      m.park();
      summarize();
   end
endmodule : tb_ddr_sram_byte_write_mask
`default_nettype wire

/* File: hw/dbm_core.sv */
// Purpose: write path of a two beat burst sram with per lane write masking
// Assumes: clk_true_i and clk_comp_i are levels sampled on sys_clk_i
// Notes: read beats are a small model of the output launch only
//
// How it works
// [RULE1] write starts at load low, select low
// [RULE2] x8: nibble selects gate bits 3:0, 7:4
// [RULE3] x18: selects gate bits 8:0 and 17:9
// [RULE4] x9: one select gates whole beat
// [RULE5] x36: four selects gate nine bit lanes
// [RULE6] all selects high writes nothing
// [RULE7] each clock edge captures own beat, mask
// [RULE8] beat masks may differ within one write
// [RULE9] beat one to A, beat two A+1
// [RULE10] read beats launch on both clock rises
// [RULE11] powers up deselected, outputs tristated
// [RULE12] controller parks clocks high when stopped
// [RULE13] selects ignored outside write data beats
`timescale 1ns/100ps
`default_nettype none
module dbm_core #(
   parameter int unsigned ADDR_W = dbm_pkg::ADDR_W,
   parameter int unsigned DATA_W = dbm_pkg::DATA_W,
   parameter int unsigned SEL_W = dbm_pkg::SEL_W,
   parameter int unsigned FIFO_DEPTH = dbm_pkg::FIFO_DEPTH,
   parameter int unsigned MEM_WORDS = 64
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire dbm_pkg::dbm_org_t org_i,
   input wire logic clk_true_i,
   input wire logic clk_comp_i,
   input wire logic load_strobe_n_i,
   input wire logic read_write_select_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic [SEL_W-1:0] byte_write_select_n_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic rdata_oe_n_o,
   output logic busy_o,
   output logic ready_o
);
   localparam int unsigned MW = $clog2(MEM_WORDS);
   localparam int unsigned BEAT_W = ADDR_W + DATA_W + SEL_W;

   // read launch steps; two wait steps give a latency of two and a half input cycles
   typedef enum logic [2:0] {
      DBM_RD_IDLE = 3'b000,
      DBM_RD_T1 = 3'b001,
      DBM_RD_T2 = 3'b010,
      DBM_RD_BEAT0 = 3'b011,
      DBM_RD_BEAT1 = 3'b100
   } dbm_rd_state_t;

   dbm_pkg::dbm_state_t state, next_state;
   dbm_rd_state_t rd_state, next_rd_state;
   logic last_true, last_comp, next_last_true, next_last_comp;
   logic [ADDR_W-1:0] wr_addr, next_wr_addr;
   logic [ADDR_W-1:0] rd_addr, next_rd_addr;
   logic [DATA_W-1:0] rdata, next_rdata;
   logic rdata_oe_n, next_rdata_oe_n;
   logic busy, next_busy;
   logic ready, next_ready;
   logic true_rise, comp_rise;
   logic beat_valid, beat_ready;
   logic [BEAT_W-1:0] beat_in, beat_out;
   logic q_valid, q_ready;
   logic [ADDR_W-1:0] q_addr;
   logic [DATA_W-1:0] q_data, merged;
   logic [SEL_W-1:0] q_sel;
   logic q_any;
   logic [DATA_W-1:0] mem [MEM_WORDS];

   function automatic logic [MW-1:0] word_index(input logic [ADDR_W-1:0] a);
      word_index = MW'(a);
   endfunction : word_index

   // burst partner address; wraps within the address width
   function automatic logic [ADDR_W-1:0] burst_next(input logic [ADDR_W-1:0] a);
      burst_next = ADDR_W'(a + 1'b1);
   endfunction : burst_next

   // a load is taken only on a true rise; rw picks read or write
   function automatic logic load_taken(input logic rise, input logic ld_n, input logic rw,
                                       input logic want_read);
      load_taken = rise && !ld_n && (rw == want_read);
   endfunction : load_taken

   always_comb begin
      true_rise = clk_true_i && !last_true;
      comp_rise = clk_comp_i && !last_comp;
      next_last_true = clk_true_i;
      next_last_comp = clk_comp_i;
   end

   // reset assumes parked high clocks, so no false rise follows reset
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         last_true <= 1'b1;
         last_comp <= 1'b1;
      end else begin
         last_true <= next_last_true;
         last_comp <= next_last_comp;
      end
   end

   // write sequencer: load, wait for the comp rise, beat on true rise then comp rise
   always_comb begin
      next_state = state;
      next_wr_addr = wr_addr;
      beat_valid = 1'b0;
      beat_in = '0;
      case (state)
         dbm_pkg::DBM_ST_IDLE: begin
            if (load_taken(true_rise, load_strobe_n_i, read_write_select_i, 1'b0)) begin
               next_wr_addr = addr_i; // RULE1
               next_state = dbm_pkg::DBM_ST_WAIT;
            end
         end
         dbm_pkg::DBM_ST_WAIT: begin
            // the comp rise of the address cycle carries no data
            if (comp_rise) begin
               next_state = dbm_pkg::DBM_ST_BEAT0;
            end
         end
         dbm_pkg::DBM_ST_BEAT0: begin
            if (true_rise) begin
               // selects sampled only here and in the next beat
               beat_valid = 1'b1; // RULE7 RULE13
               beat_in = {wr_addr, wdata_i, byte_write_select_n_i}; // RULE9
               next_state = dbm_pkg::DBM_ST_BEAT1;
            end
         end
         dbm_pkg::DBM_ST_BEAT1: begin
            if (comp_rise) begin
               beat_valid = 1'b1; // RULE7 RULE8
               beat_in = {burst_next(wr_addr), wdata_i, byte_write_select_n_i}; // RULE9
               next_state = dbm_pkg::DBM_ST_IDLE;
            end
         end
         default: begin
            next_state = dbm_pkg::DBM_ST_IDLE;
         end
      endcase
      if (state == dbm_pkg::DBM_ST_BEAT1 && comp_rise && true_rise) begin
         next_state = dbm_pkg::DBM_ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= dbm_pkg::DBM_ST_IDLE;
         wr_addr <= '0;
      end else begin
         state <= next_state;
         wr_addr <= next_wr_addr;
      end
   end

   // read beats: load at true rise t, wait for the true rises of t+1 and t+2,
   // first word on the following comp rise, second word on the true rise of t+3
   always_comb begin
      next_rd_state = rd_state;
      next_rd_addr = rd_addr;
      next_rdata = rdata;
      next_rdata_oe_n = rdata_oe_n;
      case (rd_state)
         DBM_RD_IDLE: begin
            if (load_taken(true_rise, load_strobe_n_i, read_write_select_i, 1'b1)) begin
               next_rd_addr = addr_i;
               next_rd_state = DBM_RD_T1;
            end else if (comp_rise) begin
               // bus released one comp rise after the last word
               next_rdata_oe_n = 1'b1; // RULE11
            end
         end
         DBM_RD_T1: begin
            if (true_rise) begin
               next_rd_state = DBM_RD_T2;
            end
         end
         DBM_RD_T2: begin
            if (true_rise) begin
               next_rd_state = DBM_RD_BEAT0;
            end
         end
         DBM_RD_BEAT0: begin
            if (comp_rise) begin
               next_rdata = mem[word_index(rd_addr)]; // RULE10
               next_rdata_oe_n = 1'b0;
               next_rd_state = DBM_RD_BEAT1;
            end
         end
         DBM_RD_BEAT1: begin
            if (true_rise) begin
               next_rdata = mem[word_index(burst_next(rd_addr))]; // RULE10
               next_rd_state = DBM_RD_IDLE;
            end
         end
         default: begin
            next_rd_state = DBM_RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_state <= DBM_RD_IDLE;
         rd_addr <= '0;
         rdata <= '0;
         rdata_oe_n <= 1'b1; // RULE11
      end else begin
         rd_state <= next_rd_state;
         rd_addr <= next_rd_addr;
         rdata <= next_rdata;
         rdata_oe_n <= next_rdata_oe_n;
      end
   end

   // status is registered so every output leaves a flip-flop; ready lags one cycle
   always_comb begin
      next_busy = (state != dbm_pkg::DBM_ST_IDLE) || q_valid || (rd_state != DBM_RD_IDLE);
      next_ready = beat_ready;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy <= 1'b0;
         ready <= 1'b1;
      end else begin
         busy <= next_busy;
         ready <= next_ready;
      end
   end

   dbm_fifo #(
      .WIDTH(BEAT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(beat_valid),
      .in_ready_o(beat_ready),
      .in_data_i(beat_in),
      .out_valid_o(q_valid),
      .out_ready_i(q_ready),
      .out_data_o(beat_out)
   );

   assign {q_addr, q_data, q_sel} = beat_out;
   // array update stalls only while read words launch, so beats queued by an
   // earlier write still land during the read latency and the read sees them
   assign q_ready = (rd_state != DBM_RD_BEAT0) && (rd_state != DBM_RD_BEAT1);

   dbm_lane_merge #(
      .DATA_W(DATA_W),
      .SEL_W(SEL_W)
   ) u_merge (
      .org_i(org_i),
      .old_i(mem[word_index(q_addr)]),
      .new_i(q_data),
      .sel_n_i(q_sel),
      .word_o(merged),
      .any_o(q_any)
   );

   always_ff @(posedge sys_clk_i) begin
      if (q_valid && q_ready && q_any) begin
         mem[word_index(q_addr)] <= merged; // RULE6
      end
   end

   assign rdata_o = rdata;
   assign rdata_oe_n_o = rdata_oe_n;
   assign busy_o = busy;
   assign ready_o = ready;
endmodule : dbm_core
`default_nettype wire

/* File: hw/dbm_fifo.sv */
// Purpose: write beat queue between capture and array update
// Assumes: synchronous to sys_clk_i
// Notes: full drops in_ready_o; drain side may stall
`timescale 1ns/100ps
`default_nettype none
module dbm_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [PW:0] count, next_count;
   logic push, pop;

   always_comb begin
      push = in_valid_i && (count != (PW+1)'(DEPTH));
      pop = (count != '0) && out_ready_i;
      next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (PW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // storage carries no reset so it maps to plain ram
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   assign in_ready_o = (count != (PW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
endmodule : dbm_fifo
`default_nettype wire

/* File: hw/dbm_lane_merge.sv */
// Purpose: merges one masked data beat into an array word
// Assumes: selects are active low, one per lane
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module dbm_lane_merge #(
   parameter int unsigned DATA_W = 36,
   parameter int unsigned SEL_W = 4
) (
   input wire dbm_pkg::dbm_org_t org_i,
   input wire logic [DATA_W-1:0] old_i,
   input wire logic [DATA_W-1:0] new_i,
   input wire logic [SEL_W-1:0] sel_n_i,
   output logic [DATA_W-1:0] word_o,
   output logic any_o
);
   logic [DATA_W-1:0] keep;

   always_comb begin
      keep = '1;
      for (int i = 0; i < DATA_W; i++) begin
         case (org_i)
            dbm_pkg::DBM_ORG_X8: begin
               if (i < 2 * dbm_pkg::NIB_W) begin
                  keep[i] = sel_n_i[i / dbm_pkg::NIB_W]; // RULE2
               end
            end
            dbm_pkg::DBM_ORG_X9: begin
               if (i < dbm_pkg::LANE9_W) begin
                  keep[i] = sel_n_i[0]; // RULE4
               end
            end
            dbm_pkg::DBM_ORG_X18: begin
               if (i < 2 * dbm_pkg::LANE9_W) begin
                  keep[i] = sel_n_i[i / dbm_pkg::LANE9_W]; // RULE3
               end
            end
            default: begin
               keep[i] = sel_n_i[i / dbm_pkg::LANE9_W]; // RULE5
            end
         endcase
      end
      word_o = (old_i & keep) | (new_i & ~keep);
      any_o = (keep != '1); // RULE6
   end
endmodule : dbm_lane_merge
`default_nettype wire

/* File: hw/dbm_pkg.sv */
// Purpose: shared constants for the burst sram write lane masking block
// Assumes: one system clock; both input clock phases arrive as sampled levels
// Notes: organisation codes select lane width and lane count
package dbm_pkg;
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 36;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned LANE9_W = 9;
   localparam int unsigned NIB_W = 4;
   typedef enum logic [1:0] {
      DBM_ORG_X8 = 2'b00,
      DBM_ORG_X9 = 2'b01,
      DBM_ORG_X18 = 2'b10,
      DBM_ORG_X36 = 2'b11
   } dbm_org_t;
   typedef enum logic [1:0] {
      DBM_ST_IDLE = 2'b00,
      DBM_ST_WAIT = 2'b01,
      DBM_ST_BEAT0 = 2'b10,
      DBM_ST_BEAT1 = 2'b11
   } dbm_state_t;
   localparam logic [SEL_W-1:0] SEL_NONE = 4'hf;
endpackage : dbm_pkg
